// ==== include/prl_pkg.sv ====
// Package with the register map, field layout and output carrier types.
package prl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] PRL_IDX_RATE_COUNT_CONTROL = 10'h08a;
    localparam logic [9:0] PRL_IDX_INGRESS_LIMIT_LOW = 10'h08c;
    localparam logic [9:0] PRL_IDX_INGRESS_LIMIT_HIGH = 10'h08e;
    localparam logic [9:0] PRL_IDX_EGRESS_LIMIT_LOW = 10'h090;
    localparam logic [9:0] PRL_IDX_EGRESS_LIMIT_HIGH = 10'h092;
    localparam logic [9:0] PRL_IDX_QUEUE_CONFIG = 10'h0a0;
    localparam logic [9:0] PRL_IDX_RATE_STATUS = 10'h0a2;
    localparam int PRL_ADDR_W = 12;
    localparam int PRL_ADDR_LSB = 2;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int PRL_CLASS_LSB = 2;
    localparam int PRL_GAP_BIT = 1;
    localparam int PRL_PREAMBLE_BIT = 0;
    localparam int PRL_SPLIT_BIT = 0;
    localparam int PRL_TWO_Q_BIT = 1;
    localparam int PRL_CODE_W = 7;
    localparam int PRL_CODE_LO_LSB = 0;
    localparam int PRL_CODE_HI_LSB = 8;
    localparam int PRL_NUM_PRIO = 4;

    ////////////////////////////////////////////////////////////////////////
    // Writable masks and reset values.
    localparam logic [15:0] PRL_MASK_CONTROL = 16'h001f;
    localparam logic [15:0] PRL_MASK_QUEUE = 16'h0003;
    localparam logic [15:0] PRL_RESET_VALUE = 16'h0000;
    localparam logic [6:0] PRL_CODE_FULL_RATE = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    // Overhead bytes per frame and queue counts.
    localparam logic [4:0] PRL_GAP_BYTES = 5'h0c;
    localparam logic [4:0] PRL_PREAMBLE_BYTES = 5'h08;
    localparam logic [2:0] PRL_QUEUES_ONE = 3'h1;
    localparam logic [2:0] PRL_QUEUES_TWO = 3'h2;
    localparam logic [2:0] PRL_QUEUES_FOUR = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // AXI responses.
    localparam logic [1:0] PRL_RESP_OKAY = 2'h0;
    localparam logic [1:0] PRL_RESP_SLVERR = 2'h2;

    // Frame classes counted against the ingress limit.
    typedef enum logic [1:0] {
        PRL_CLASS_ALL = 2'h0,
        PRL_CLASS_BC_MC_FLOOD = 2'h1,
        PRL_CLASS_BC_MC = 2'h2,
        PRL_CLASS_BC = 2'h3
    } prl_class_t;

    // Settings handed to the switch datapath.
    typedef struct packed {
        prl_class_t ingress_class;
        logic count_gap;
        logic count_preamble;
        logic [4:0] overhead_bytes;
        logic [3:0][6:0] ingress_code;
        logic [3:0] ingress_limit_on;
        logic [2:0] egress_queues;
        logic [3:0][6:0] egress_code;
        logic [3:0] egress_limit_on;
    } prl_rate_cfg_t;

endpackage

// ==== design/prl_port_rate_cfg.sv ====
// Port 2 rate-limit configuration registers with an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Control bits 3..2 select frame classes counted on ingress.
// - Gap bit adds twelve bytes per frame to both rates.
// - Preamble bit adds eight bytes per frame to both rates.
// - Ingress low bits 14..8: priority-1 ingress code.
// - Ingress low bits 6..0: priority-0 ingress code.
// - Ingress high bits 14..8: priority-3 ingress code.
// - Ingress high bits 6..0: priority-2 ingress code.
// - Code zero, the reset value, means full line rate.
// - Egress low bits 14..8: priority-1 egress code.
// - Egress low bits 6..0: priority-0 egress code.
// - One egress queue applies only the priority-0 limit.
// - Two egress queues apply only priority-1 and priority-0 limits.
// - Egress high holds priority-3 and priority-2 egress codes.
// - Egress high bits 14..8: priority 3; bits 6..0: priority 2.
// - Split bit picks one queue or priority queues.
module prl_port_rate_cfg (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output prl_pkg::prl_rate_cfg_t rate_cfg
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage and bus bookkeeping.
    logic [15:0] control_ff;
    logic [15:0] ingress_low_ff;
    logic [15:0] ingress_high_ff;
    logic [15:0] egress_low_ff;
    logic [15:0] egress_high_ff;
    logic [15:0] queue_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [9:0] waddr_ff;
    logic [15:0] wdata_ff;
    logic [1:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    prl_pkg::prl_rate_cfg_t cfg_ff;
    prl_pkg::prl_rate_cfg_t nxt_cfg;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    logic [15:0] byte_mask;
    logic [15:0] wr_bits;
    logic wr_hit;
    logic [15:0] status_word;
    logic [15:0] rd_word;
    logic rd_hit;
    logic [9:0] rd_idx;

    ////////////////////////////////////////////////////////////////////////
    // Readies drop while the clock enable is low, so a frozen block
    // takes no transfer.
    assign s_axi_awready = ce && !aw_held_ff;
    assign s_axi_wready = ce && !w_held_ff;
    assign s_axi_arready = ce && !rvalid_ff;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    // The write lands once both halves are held and the last answer is gone.
    assign do_write = ce && aw_held_ff && w_held_ff && !bvalid_ff;

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rate_cfg = cfg_ff;

    // Only the two low byte lanes carry register bits.
    assign byte_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wr_bits = wdata_ff & byte_mask;

    // Write address decode.
    always_comb begin
        case (waddr_ff)
            prl_pkg::PRL_IDX_RATE_COUNT_CONTROL,
            prl_pkg::PRL_IDX_INGRESS_LIMIT_LOW,
            prl_pkg::PRL_IDX_INGRESS_LIMIT_HIGH,
            prl_pkg::PRL_IDX_EGRESS_LIMIT_LOW,
            prl_pkg::PRL_IDX_EGRESS_LIMIT_HIGH,
            prl_pkg::PRL_IDX_QUEUE_CONFIG,
            prl_pkg::PRL_IDX_RATE_STATUS: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Address capture; address and data come in either order.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_held_ff <= 1'b0;
            waddr_ff <= 10'h000;
        end else if (aw_fire) begin
            aw_held_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr[prl_pkg::PRL_ADDR_W-1:prl_pkg::PRL_ADDR_LSB];
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    // Write data capture.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            w_held_ff <= 1'b0;
            wdata_ff <= 16'h0000;
            wstrb_ff <= 2'h0;
        end else if (w_fire) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[15:0];
            wstrb_ff <= s_axi_wstrb[1:0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    // Write answer; unmapped addresses get a slave error.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= prl_pkg::PRL_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? prl_pkg::PRL_RESP_OKAY
                                   : prl_pkg::PRL_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control keeps bits 4..0; upper bits are never stored or changed.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_ff <= prl_pkg::PRL_RESET_VALUE;
        end else if (do_write &&
                     waddr_ff == prl_pkg::PRL_IDX_RATE_COUNT_CONTROL) begin
            control_ff <= (control_ff & ~(byte_mask & prl_pkg::PRL_MASK_CONTROL))
                        | (wr_bits & prl_pkg::PRL_MASK_CONTROL);
        end
    end

    // Ingress codes, zero (full rate) at reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ingress_low_ff <= prl_pkg::PRL_RESET_VALUE;
            ingress_high_ff <= prl_pkg::PRL_RESET_VALUE;
        end else if (do_write) begin
            if (waddr_ff == prl_pkg::PRL_IDX_INGRESS_LIMIT_LOW) begin
                ingress_low_ff <= (ingress_low_ff & ~byte_mask) | wr_bits;
            end
            if (waddr_ff == prl_pkg::PRL_IDX_INGRESS_LIMIT_HIGH) begin
                ingress_high_ff <= (ingress_high_ff & ~byte_mask) | wr_bits;
            end
        end
    end

    // Egress codes, zero (full rate) at reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            egress_low_ff <= prl_pkg::PRL_RESET_VALUE;
            egress_high_ff <= prl_pkg::PRL_RESET_VALUE;
        end else if (do_write) begin
            if (waddr_ff == prl_pkg::PRL_IDX_EGRESS_LIMIT_LOW) begin
                egress_low_ff <= (egress_low_ff & ~byte_mask) | wr_bits;
            end
            if (waddr_ff == prl_pkg::PRL_IDX_EGRESS_LIMIT_HIGH) begin
                egress_high_ff <= (egress_high_ff & ~byte_mask) | wr_bits;
            end
        end
    end

    // Queue arrangement; one queue after reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            queue_ff <= prl_pkg::PRL_RESET_VALUE;
        end else if (do_write &&
                     waddr_ff == prl_pkg::PRL_IDX_QUEUE_CONFIG) begin
            queue_ff <= (queue_ff & ~(byte_mask & prl_pkg::PRL_MASK_QUEUE))
                      | (wdata_ff & byte_mask & prl_pkg::PRL_MASK_QUEUE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path. The status word reflects the settings the datapath is
    // actually using, so it lags a write by one cycle.
    assign status_word = {5'h00, cfg_ff.egress_queues,
                          cfg_ff.ingress_limit_on, cfg_ff.egress_limit_on};
    assign rd_idx = s_axi_araddr[prl_pkg::PRL_ADDR_W-1:prl_pkg::PRL_ADDR_LSB];

    always_comb begin
        rd_hit = 1'b1;
        case (rd_idx)
            prl_pkg::PRL_IDX_RATE_COUNT_CONTROL: begin
                rd_word = control_ff & prl_pkg::PRL_MASK_CONTROL;
            end
            prl_pkg::PRL_IDX_INGRESS_LIMIT_LOW: rd_word = ingress_low_ff;
            prl_pkg::PRL_IDX_INGRESS_LIMIT_HIGH: rd_word = ingress_high_ff;
            prl_pkg::PRL_IDX_EGRESS_LIMIT_LOW: rd_word = egress_low_ff;
            prl_pkg::PRL_IDX_EGRESS_LIMIT_HIGH: rd_word = egress_high_ff;
            prl_pkg::PRL_IDX_QUEUE_CONFIG: rd_word = queue_ff;
            prl_pkg::PRL_IDX_RATE_STATUS: begin
                rd_word = status_word;
            end
            default: begin
                rd_word = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read answer, held until the master takes it.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= prl_pkg::PRL_RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {16'h0000, rd_word};
                rresp_ff <= rd_hit ? prl_pkg::PRL_RESP_OKAY
                                   : prl_pkg::PRL_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived datapath settings.
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_cfg.ingress_class = prl_pkg::prl_class_t'(
            control_ff[prl_pkg::PRL_CLASS_LSB +: 2]);
        nxt_cfg.count_gap = control_ff[prl_pkg::PRL_GAP_BIT];
        nxt_cfg.count_preamble = control_ff[prl_pkg::PRL_PREAMBLE_BIT];
        // One overhead figure serves ingress and egress alike.
        nxt_cfg.overhead_bytes =
            (control_ff[prl_pkg::PRL_GAP_BIT] ? prl_pkg::PRL_GAP_BYTES
                                               : 5'h00)
          + (control_ff[prl_pkg::PRL_PREAMBLE_BIT] ? prl_pkg::PRL_PREAMBLE_BYTES
                                                    : 5'h00);
        // Split off means one queue; split on means four unless two chosen.
        if (!queue_ff[prl_pkg::PRL_SPLIT_BIT]) begin
            nxt_cfg.egress_queues = prl_pkg::PRL_QUEUES_ONE;
        end else if (queue_ff[prl_pkg::PRL_TWO_Q_BIT]) begin
            nxt_cfg.egress_queues = prl_pkg::PRL_QUEUES_TWO;
        end else begin
            nxt_cfg.egress_queues = prl_pkg::PRL_QUEUES_FOUR;
        end
    end

    // Priorities 0 and 1 sit low, 2 and 3 high; odd ones use bits 14..8.
    logic [3:0][6:0] ingress_code;
    logic [3:0][6:0] egress_code;
    logic [3:0][6:0] egress_applied;
    logic [3:0] ingress_on;
    logic [3:0] egress_on;

    genvar p;
    generate
        for (p = 0; p < prl_pkg::PRL_NUM_PRIO; p = p + 1) begin : g_prio
            localparam int LSB = (p % 2 == 1) ? prl_pkg::PRL_CODE_HI_LSB
                                              : prl_pkg::PRL_CODE_LO_LSB;
            localparam logic [2:0] NEED = 3'(p + 1);
            if (p < 2) begin : g_low
                assign ingress_code[p] =
                    ingress_low_ff[LSB +: prl_pkg::PRL_CODE_W];
                assign egress_code[p] =
                    egress_low_ff[LSB +: prl_pkg::PRL_CODE_W];
            end else begin : g_high
                assign ingress_code[p] =
                    ingress_high_ff[LSB +: prl_pkg::PRL_CODE_W];
                assign egress_code[p] =
                    egress_high_ff[LSB +: prl_pkg::PRL_CODE_W];
            end
            // Codes past the queue count read as full rate, so a stale
            // code cannot throttle a merged queue.
            assign egress_applied[p] =
                (nxt_cfg.egress_queues >= NEED) ? egress_code[p]
                                                : prl_pkg::PRL_CODE_FULL_RATE;
            // Zero means no ceiling; anything else indexes the rate table.
            assign ingress_on[p] =
                ingress_code[p] != prl_pkg::PRL_CODE_FULL_RATE;
            assign egress_on[p] =
                egress_applied[p] != prl_pkg::PRL_CODE_FULL_RATE;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Settings to the datapath, registered.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_ff <= '0;
            cfg_ff.egress_queues <= prl_pkg::PRL_QUEUES_ONE;
        end else if (ce) begin
            cfg_ff <= nxt_cfg;
            cfg_ff.ingress_code <= ingress_code;
            cfg_ff.ingress_limit_on <= ingress_on;
            cfg_ff.egress_code <= egress_applied;
            cfg_ff.egress_limit_on <= egress_on;
        end
    end

endmodule

`default_nettype wire

// ==== test/prl_port_rate_cfg_sva.sv ====
// Checker of the port 2 rate-limit configuration block ports.
`timescale 1ns/1ps
`default_nettype none
module prl_port_rate_cfg_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire prl_pkg::prl_rate_cfg_t rate_cfg
);
    // One clock domain.
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////
    // Settings agree with their fields.
    property p_overhead;
        rate_cfg.overhead_bytes == (rate_cfg.count_gap ? 5'h0c : 5'h00)
            + (rate_cfg.count_preamble ? 5'h08 : 5'h00);
    endproperty
    a_overhead: assert property (p_overhead)
        else $error("overhead bytes disagree with the count flags");
    property p_limit_on;
        rate_cfg.egress_limit_on == {rate_cfg.egress_code[3] != 7'h00,
            rate_cfg.egress_code[2] != 7'h00, rate_cfg.egress_code[1] != 7'h00,
            rate_cfg.egress_code[0] != 7'h00} && rate_cfg.ingress_limit_on[0]
            == (rate_cfg.ingress_code[0] != 7'h00);
    endproperty
    a_limit_on: assert property (p_limit_on)
        else $error("limit enable disagrees with its code");
    property p_q_legal;
        rate_cfg.egress_queues inside {3'h1, 3'h2, 3'h4};
    endproperty
    a_q_legal: assert property (p_q_legal)
        else $error("egress queue count is not one, two or four");
    // Codes past the queue count are not applied.
    property p_eg_unused;
        rate_cfg.egress_queues != 3'h4 |-> rate_cfg.egress_code[3] == '0
            && rate_cfg.egress_code[2] == '0 && (rate_cfg.egress_queues
            == 3'h2 || rate_cfg.egress_code[1] == '0);
    endproperty
    a_eg_unused: assert property (p_eg_unused)
        else $error("egress code applied beyond the queue count");

    ////////////////////////////////////////////////
    // Bus answers come on time and stand until taken.
    property p_b_after;
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
            ##1 ce |=> s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response missing after address and data");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before it was taken");
    property p_r_after;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_after: assert property (p_r_after)
        else $error("read data missing after the address");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready
            && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data changed before it was taken");
    property p_ce_ready;
        !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
    endproperty
    a_ce_ready: assert property (p_ce_ready)
        else $error("ready high while the clock enable is low");
    // Never disabled: reset is the cause.
    property p_reset;
        disable iff (1'b0) rst |=> rate_cfg.egress_queues == 3'h1
            && rate_cfg.ingress_code == '0 && rate_cfg.egress_code == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("settings not at full rate after reset");
endmodule

bind prl_port_rate_cfg prl_port_rate_cfg_sva u_prl_port_rate_cfg_sva (
    .core_clk, .rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .rate_cfg);
`default_nettype wire

// ==== test/prl_port_rate_cfg_bench.sv ====
// Self-checking bench of the port 2 rate-limit configuration block.
`timescale 1ns/1ps
`default_nettype none
module prl_port_rate_cfg_bench;
    localparam int CYCLE_LIMIT = 20000;
    localparam I_CTRL = prl_pkg::PRL_IDX_RATE_COUNT_CONTROL;
    localparam I_ILO = prl_pkg::PRL_IDX_INGRESS_LIMIT_LOW;
    localparam I_IHI = prl_pkg::PRL_IDX_INGRESS_LIMIT_HIGH;
    localparam I_ELO = prl_pkg::PRL_IDX_EGRESS_LIMIT_LOW;
    localparam I_EHI = prl_pkg::PRL_IDX_EGRESS_LIMIT_HIGH;
    localparam I_QCFG = prl_pkg::PRL_IDX_QUEUE_CONFIG;
    localparam I_STAT = prl_pkg::PRL_IDX_RATE_STATUS;
    logic core_clk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, w;
    logic [3:0] s_axi_wstrb, eon, s;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] ing_lo, ing_hi, v, d;
    logic [2:0] nq;
    logic [6:0] ec;
    logic [9:0] idx_tab [7] = '{I_CTRL, I_ILO, I_IHI, I_ELO, I_EHI, I_QCFG,
        I_STAT};
    prl_pkg::prl_rate_cfg_t rate_cfg;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    prl_port_rate_cfg u_prl_port_rate_cfg (.core_clk, .rst, .ce,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rate_cfg);

    // Free-running clock of 8 ns.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hung handshake ends the run here.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            err_count = err_count + 1;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [3:0] exp_on(input logic [15:0] lo, hi);
        return {hi[14:8] != 7'h00, hi[6:0] != 7'h00, lo[14:8] != 7'h00,
            lo[6:0] != 7'h00};
    endfunction

    ////////////////////////////////////////////////
    // Answer readies rise after a random wait, so answers must stand.
    task automatic axi_write(input logic [9:0] idx, input logic [15:0] dat,
                             input logic [3:0] stb, output logic [1:0] resp);
        logic done = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'($urandom), dat};
        s_axi_wstrb <= stb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                resp = s_axi_bresp;
                done = 1'b1;
                s_axi_bready <= 1'b0;
            end else if (!s_axi_bready) s_axi_bready <= 1'($urandom);
        end
    endtask

    task automatic axi_read(input logic [9:0] idx, output logic [31:0] dat,
                            output logic [1:0] resp);
        logic done = 1'b0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        while (!done) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                dat = s_axi_rdata;
                resp = s_axi_rresp;
                done = 1'b1;
                s_axi_rready <= 1'b0;
            end else if (!s_axi_rready) s_axi_rready <= 1'($urandom);
        end
    endtask

    ////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {rst, ce} = 2'b11;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
            s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb,
            s_axi_wdata} = '0;
        void'($urandom(32'h5d10_65b7));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (idx_tab[k]) begin
            axi_read(idx_tab[k], rd, rsp);
            check("reset value", rd, (k == 6) ? 32'h0000_0100 : '0);
        end
        // All control codes, random reserved bits.
        for (int i = 0; i < 32; i++) begin
            v = {11'($urandom), i[4:0]};
            axi_write(I_CTRL, v, 4'h3, rsp);
            @(posedge core_clk);
            check("class", rate_cfg.ingress_class, v[3:2]);
            check("gap", rate_cfg.count_gap, v[1]);
            check("preamble", rate_cfg.count_preamble, v[0]);
            check("overhead", rate_cfg.overhead_bytes,
                (v[1] ? 12 : 0) + (v[0] ? 8 : 0));
            axi_read(I_CTRL, rd, rsp);
            check("control read", rd, {27'h0, v[4:0]});
        end
        // Ingress codes with zero and reserved-only corners.
        for (int i = 0; i < 8; i++) begin
            ing_lo = (i == 0) ? '0 : (i == 1) ? 16'h7f7f : 16'($urandom);
            ing_hi = (i == 1) ? 16'h8080 : 16'($urandom);
            axi_write(I_ILO, ing_lo, 4'h3, rsp);
            axi_write(I_IHI, ing_hi, 4'h3, rsp);
            @(posedge core_clk);
            check("ingress p0", rate_cfg.ingress_code[0], ing_lo[6:0]);
            check("ingress p1", rate_cfg.ingress_code[1], ing_lo[14:8]);
            check("ingress p2", rate_cfg.ingress_code[2], ing_hi[6:0]);
            check("ingress p3", rate_cfg.ingress_code[3], ing_hi[14:8]);
            check("ingress on", rate_cfg.ingress_limit_on,
                exp_on(ing_lo, ing_hi));
            axi_read(I_IHI, rd, rsp);
            check("ingress read", rd, {16'h0, ing_hi});
        end
        // Byte strobes, the upper two of which change nothing.
        for (int k = 0; k < 3; k++) begin
            s = (k == 0) ? 4'h1 : (k == 1) ? 4'h2 : 4'hc;
            d = 16'($urandom);
            axi_write(I_ILO, d, s, rsp);
            ing_lo = {s[1] ? d[15:8] : ing_lo[15:8], s[0] ? d[7:0] : ing_lo[7:0]};
            axi_read(I_ILO, rd, rsp);
            check("strobe read", rd, {16'h0, ing_lo});
        end
        // Each queue mode; ignored nonzero codes must vanish.
        for (int q = 0; q < 4; q++) begin
            w = 32'($urandom) | 32'h0101_0101;
            axi_write(I_QCFG, 16'(q), 4'h3, rsp);
            axi_write(I_ELO, w[15:0], 4'h3, rsp);
            axi_write(I_EHI, w[31:16], 4'h3, rsp);
            @(posedge core_clk);
            nq = q[0] ? (q[1] ? 3'h2 : 3'h4) : 3'h1;
            check("queues", rate_cfg.egress_queues, nq);
            for (int p = 0; p < 4; p++) begin
                ec = (p < nq) ? w[8 * p +: 7] : 7'h00;
                eon[p] = (ec != 7'h00);
                check("egress code", rate_cfg.egress_code[p], ec);
            end
            check("egress on", rate_cfg.egress_limit_on, eon);
            axi_read(I_EHI, rd, rsp);
            check("egress read", rd, {16'h0, w[31:16]});
            axi_write(I_STAT, 16'hffff, 4'h3, rsp);
            check("status bresp", rsp, prl_pkg::PRL_RESP_OKAY);
            axi_read(I_STAT, rd, rsp);
            check("status", rd, {21'h0, nq, exp_on(ing_lo, ing_hi), eon});
        end
        // Unmapped place: error answer, reads as zero.
        axi_write(10'h0c0, 16'hffff, 4'h3, rsp);
        check("unmapped bresp", rsp, prl_pkg::PRL_RESP_SLVERR);
        axi_read(10'h0c0, rd, rsp);
        check("unmapped rdata", rd, '0);
        check("unmapped rresp", rsp, prl_pkg::PRL_RESP_SLVERR);
        // Readies drop while the clock enable is low.
        ce <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("readies", {s_axi_awready, s_axi_wready, s_axi_arready}, '0);
        ce <= 1'b1;
        // Mid-run reset restores full rate.
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check("queues reset", rate_cfg.egress_queues, 3'h1);
        axi_read(I_ILO, rd, rsp);
        check("ingress reset", rd, '0);
        conclude();
    end
endmodule
`default_nettype wire
